//--- hdl/wmh_pkg.sv
// Package: constants, power states and carriers for the wireless module host port
package wmh_pkg;

  // Core clock rate and boot time after the module reset pin is released
  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned BOOT_TIME_MS = 300;
  localparam int unsigned BOOT_CYCLES  = BOOT_TIME_MS * CLK_MHZ * 1000;

  // Serial link and data buffer shape
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned FIFO_DEPTH  = 32;
  localparam int unsigned BIT_CNT_W   = 3;
  localparam logic [7:0]  IDLE_BYTE   = 8'h00;

  // Reset values of the power-save enable and the alert line
  localparam logic PS_EN_RST  = 1'b0;
  localparam logic ALERT_RST  = 1'b0;

  // Synchroniser lanes
  localparam int unsigned SY_DEEP  = 0;
  localparam int unsigned SY_MRST  = 1;
  localparam int unsigned SY_SUP   = 2;
  localparam int unsigned SY_CS    = 3;
  localparam int unsigned SY_SCK   = 4;
  localparam int unsigned SY_MOSI  = 5;
  localparam int unsigned SY_W     = 6;

  // Power states; standby is reached only by internal transitions
  typedef enum logic [2:0] {
    ST_HIBERNATE,
    ST_RESET,
    ST_BOOT,
    ST_STANDBY,
    ST_SLEEP,
    ST_BEACON,
    ST_RX_ACTIVE,
    ST_TX_ACTIVE
  } wmh_pwr_t;

  // Serial pins as they arrive from the host
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic mosi;
  } wmh_spi_in_t;

  // Status seen by the radio side
  typedef struct packed {
    wmh_pwr_t state;
    logic     core_en;
    logic     ready;
  } wmh_stat_t;

endpackage

//--- hdl/wmh_spi_power_ctrl.sv
// Host serial port, alert line and power-state control of the wireless module
// Operation
// - Deep-off input high keeps core regulators disabled; without valid supply the core sits in reset with core_en high.
// - Hibernate keeps no state; configuration is lost on wake.
// - Power-on reset holds module until supply is valid.
// - Module needs about 300 ms after reset release; host monitors.
// - With power save enabled, sleep once all activity is done.
// - In sleep, wake alone at each beacon to check traffic.
// - Queued traffic is fetched, then host is alerted normally.
// - No queued traffic: return to sleep until next beacon.
// - Active state has receive and transmit substates.
// - Standby is internal only; host cannot select it.
// - Alert line low while data waits for the host.
// - Alert line released once pending data went out.
// - Serial modes 0 and 3 only.
// - First data bit captured on first rising edge after select.
// - Bytes move most significant bit first, both directions.
// - Select falling edge starts a transfer.
// - Select rising edge ends the transfer.
`timescale 1ns/100ps
`default_nettype none

module wmh_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset
  input  wire  logic         i_clk,
  input  wire  logic         i_rst_n,
  input  wire  logic         i_flush,
  // Fill side
  input  wire  logic         i_in_valid,
  output logic               o_in_ready,
  input  wire  logic [W-1:0] i_in_data,
  // Drain side
  output logic               o_out_valid,
  input  wire  logic         i_out_ready,
  output logic [W-1:0]       o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   cnt_r;
  wire           push;
  wire           pop;

  // Full and empty straight from the occupancy count
  assign o_in_ready  = (cnt_r != (AW+1)'(DEPTH)) && !i_flush;
  assign o_out_valid = (cnt_r != '0) && !i_flush;
  assign o_out_data  = mem[rd_ptr_r];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Storage array, no reset needed
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= i_in_data;
    end
  end

  // Pointers; flush drops everything at once
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || i_flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // wmh_fifo

module wmh_spi_power_ctrl #(
  parameter int unsigned BOOT_CYC = wmh_pkg::BOOT_CYCLES,
  parameter int unsigned DEPTH    = wmh_pkg::FIFO_DEPTH
) (
  // Clock and synchronous reset
  input  wire  logic                     i_clk,
  input  wire  logic                     i_rst_n,
  // Power pins from the host and supply monitor
  input  wire  logic                     i_deep_off,
  input  wire  logic                     i_mod_rst_n,
  input  wire  logic                     i_supply_ok,
  // Serial port pins
  input  wire  wmh_pkg::wmh_spi_in_t     i_spi,
  output logic                           o_spi_miso,
  // Open-drain alert line
  output logic                           o_alert_out,
  output logic                           o_alert_oe_n,
  // Configuration from the radio side
  input  wire  logic                     i_cfg_we,
  input  wire  logic                     i_cfg_ps_en,
  // Radio activity
  input  wire  logic                     i_tx_req,
  input  wire  logic                     i_tx_done,
  input  wire  logic                     i_rx_start,
  input  wire  logic                     i_rx_done,
  input  wire  logic                     i_beacon,
  input  wire  logic                     i_beacon_traffic,
  // Received data for the host
  input  wire  logic                     i_rx_valid,
  input  wire  logic [7:0]               i_rx_data,
  output logic                           o_rx_ready,
  // Bytes written by the host
  output logic                           o_host_vld,
  output logic [7:0]                     o_host_byte,
  output logic                           o_xfer_start,
  output logic                           o_xfer_end,
  // Status
  output wmh_pkg::wmh_stat_t             o_stat
);
  import wmh_pkg::*;

  localparam int unsigned CW = $clog2(BOOT_CYC + 1);

  // Two-flop synchronisers plus one edge stage
  logic [SY_W-1:0] sy1_r;
  logic [SY_W-1:0] sy2_r;
  logic            cs_d_r;
  logic            sck_d_r;

  wmh_pwr_t state_r;
  wmh_pwr_t state_nxt;
  logic [CW-1:0] boot_cnt_r;
  logic          ps_en_r;
  logic          alert_r;
  logic [7:0]    tx_sh_r;
  logic [7:0]    rx_sh_r;
  logic [BIT_CNT_W-1:0] bit_cnt_r;
  logic          first_r;
  logic          pend_r;
  logic          host_vld_r;
  logic [7:0]    host_byte_r;
  logic          start_r;
  logic          end_r;

  // Synchronised pin levels
  wire deep_s   = sy2_r[SY_DEEP];
  wire mrst_n_s = sy2_r[SY_MRST];
  wire sup_s    = sy2_r[SY_SUP];
  wire cs_n_s   = sy2_r[SY_CS];
  wire sck_s    = sy2_r[SY_SCK];
  wire mosi_s   = sy2_r[SY_MOSI];

  // Supply monitor folds into the internal reset
  wire por_rst  = !i_rst_n || !sup_s;

  // Serial edges, only meaningful while the port is up
  wire op_st    = (state_r == ST_STANDBY) || (state_r == ST_SLEEP)
               || (state_r == ST_BEACON) || (state_r == ST_RX_ACTIVE)
               || (state_r == ST_TX_ACTIVE);
  wire cs_act   = !cs_n_s && op_st;
  wire cs_fall  = cs_d_r && !cs_n_s && op_st;
  wire cs_rise  = !cs_d_r && cs_n_s && op_st;
  wire sck_rise = cs_act && !cs_fall && sck_s && !sck_d_r;
  wire sck_fall = cs_act && !cs_fall && !sck_s && sck_d_r;
  wire byte_end = sck_rise && (bit_cnt_r == BIT_CNT_W'(7));
  wire ld_next  = sck_fall && !first_r && (bit_cnt_r == '0);

  // Buffer handshake toward the shifter
  wire       fifo_vld;
  wire [7:0] fifo_data;
  // Head is only peeked at load and popped once its eighth bit is out, so the
  // trailing fall of a mode 0 frame cannot swallow a byte
  wire       tx_load  = cs_fall || ld_next;
  wire       fifo_pop = byte_end && pend_r;
  wire       flush    = (state_r == ST_HIBERNATE) || (state_r == ST_RESET);

  // Sleep is allowed only when nothing is pending anywhere
  wire idle_all = !i_tx_req && !i_rx_start && !fifo_vld && !pend_r
               && !cs_act;

  // Boot count expired
  wire boot_done = (boot_cnt_r == CW'(BOOT_CYC));

  // Capture every pin twice before use
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sy1_r <= '0;
      sy2_r <= '0;
    end else begin
      sy1_r <= {i_spi.mosi, i_spi.sck, i_spi.cs_n,
                i_supply_ok, i_mod_rst_n, i_deep_off};
      sy2_r <= sy1_r;
    end
  end

  // Power-state sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_HIBERNATE: begin
        if (!deep_s) begin
          state_nxt = ST_RESET;
        end
      end
      ST_RESET: begin
        if (mrst_n_s) begin
          state_nxt = ST_BOOT;
        end
      end
      ST_BOOT: begin
        if (boot_done) begin
          state_nxt = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        if (i_tx_req) begin
          state_nxt = ST_TX_ACTIVE;
        end else if (i_rx_start) begin
          state_nxt = ST_RX_ACTIVE;
        end else if (ps_en_r && idle_all) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (i_tx_req || cs_act) begin
          state_nxt = ST_STANDBY;
        end else if (i_beacon) begin
          state_nxt = ST_BEACON;
        end
      end
      ST_BEACON: begin
        if (i_beacon_traffic) begin
          state_nxt = ST_RX_ACTIVE;
        end else begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_RX_ACTIVE: begin
        if (i_rx_done) begin
          state_nxt = ST_STANDBY;
        end
      end
      ST_TX_ACTIVE: begin
        if (i_tx_done) begin
          state_nxt = ST_STANDBY;
        end
      end
      default: begin
        state_nxt = ST_HIBERNATE;
      end
    endcase
    // Deep-off and module reset override everything
    if (deep_s) begin
      state_nxt = ST_HIBERNATE;
    end else if (!mrst_n_s && state_r != ST_HIBERNATE) begin
      state_nxt = ST_RESET;
    end
  end

  // State register; power-on reset parks the module in reset
  always_ff @(posedge i_clk) begin
    if (por_rst) begin
      state_r <= ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Boot timer runs only while booting
  always_ff @(posedge i_clk) begin
    if (por_rst || state_r != ST_BOOT) begin
      boot_cnt_r <= '0;
    end else if (!boot_done) begin
      boot_cnt_r <= boot_cnt_r + 1'b1;
    end
  end

  // Power-save setting is wiped whenever the core loses state
  always_ff @(posedge i_clk) begin
    if (por_rst || flush) begin
      ps_en_r <= PS_EN_RST;
    end else if (i_cfg_we) begin
      ps_en_r <= i_cfg_ps_en;
    end
  end

  // Edge-detect stage reads only the second flop
  always_ff @(posedge i_clk) begin
    if (por_rst) begin
      cs_d_r  <= 1'b1;
      sck_d_r <= 1'b0;
    end else begin
      cs_d_r  <= cs_n_s;
      sck_d_r <= sck_s;
    end
  end

  // Bit counter; mode 3 opens with a falling edge that must not shift
  always_ff @(posedge i_clk) begin
    if (por_rst || !cs_act) begin
      bit_cnt_r <= '0;
      first_r   <= 1'b1;
    end else if (sck_rise) begin
      bit_cnt_r <= bit_cnt_r + 1'b1;
      first_r   <= 1'b0;
    end
  end

  // Receive shifter, sampled on the rising edge, MSB first
  always_ff @(posedge i_clk) begin
    if (por_rst) begin
      rx_sh_r <= '0;
    end else if (sck_rise) begin
      rx_sh_r <= {rx_sh_r[6:0], mosi_s};
    end
  end

  // Transmit shifter, moves on the falling edge
  always_ff @(posedge i_clk) begin
    if (por_rst || flush) begin
      tx_sh_r <= IDLE_BYTE;
    end else if (cs_fall || ld_next) begin
      tx_sh_r <= fifo_vld ? fifo_data : IDLE_BYTE;
    end else if (sck_fall && !first_r) begin
      tx_sh_r <= {tx_sh_r[6:0], 1'b0};
    end
  end

  // A loaded data byte stays pending until its eighth bit is out or select rises
  always_ff @(posedge i_clk) begin
    if (por_rst || flush) begin
      pend_r <= 1'b0;
    end else if (tx_load && fifo_vld) begin
      pend_r <= 1'b1;
    end else if (byte_end || cs_rise) begin
      pend_r <= 1'b0;
    end
  end

  // Host byte and transfer framing pulses
  always_ff @(posedge i_clk) begin
    if (por_rst) begin
      host_vld_r  <= 1'b0;
      host_byte_r <= '0;
      start_r     <= 1'b0;
      end_r       <= 1'b0;
    end else begin
      host_vld_r  <= byte_end;
      start_r     <= cs_fall;
      end_r       <= cs_rise;
      if (byte_end) begin
        host_byte_r <= {rx_sh_r[6:0], mosi_s};
      end
    end
  end

  // Alert follows waiting data; never raised while booting or past the first cycle off
  always_ff @(posedge i_clk) begin
    if (por_rst) begin
      alert_r <= ALERT_RST;
    end else begin
      alert_r <= op_st && (fifo_vld || pend_r);
    end
  end

  // Fetched radio data waits here for the host; radio stalls when full
  wmh_fifo #(
    .W     (BYTE_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst_n     (!por_rst),
    .i_flush     (flush),
    .i_in_valid  (i_rx_valid && op_st),
    .o_in_ready  (o_rx_ready),
    .i_in_data   (i_rx_data),
    .o_out_valid (fifo_vld),
    .i_out_ready (fifo_pop),
    .o_out_data  (fifo_data)
  );

  // Output pins and status
  assign o_spi_miso    = tx_sh_r[7];
  assign o_alert_out   = 1'b0;
  assign o_alert_oe_n  = !alert_r;
  assign o_host_vld    = host_vld_r;
  assign o_host_byte   = host_byte_r;
  assign o_xfer_start  = start_r;
  assign o_xfer_end    = end_r;
  assign o_stat.state   = state_r;
  assign o_stat.core_en = (state_r != ST_HIBERNATE);
  assign o_stat.ready   = op_st;

endmodule // wmh_spi_power_ctrl

`default_nettype wire

//--- testbench/wmh_props.sv
// Concurrent checks on the host port outputs
`timescale 1ns/100ps
`default_nettype none
module wmh_props #(
  parameter int unsigned BOOT_CYC = 20
) (
  // Clock, reset and pins
  input wire logic                 i_clk,
  input wire logic                 i_rst_n,
  input wire logic                 i_deep_off,
  input wire logic                 i_supply_ok,
  input wire wmh_pkg::wmh_spi_in_t i_spi,
  // Radio side and outputs
  input wire logic                 i_beacon,
  input wire logic                 i_beacon_traffic,
  input wire logic                 i_rx_valid,
  input wire logic                 o_rx_ready,
  input wire logic                 o_alert_oe_n,
  input wire logic                 o_host_vld,
  input wire logic                 o_xfer_start,
  input wire logic                 o_xfer_end,
  input wire wmh_pkg::wmh_stat_t   o_stat
);
  import wmh_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wmh_pwr_t    st;
  logic        off;
  logic [31:0] boot_cnt_r;
  // Offline states never serve the host
  assign st  = o_stat.state;
  assign off = (st == ST_HIBERNATE) || (st == ST_RESET) || (st == ST_BOOT);
  // Boot dwell counter; too long a boot to unroll as a repetition
  always_ff @(posedge i_clk) begin
    boot_cnt_r <= (st == ST_BOOT) ? boot_cnt_r + 32'h1 : 32'h0;
  end
  // Sleep, then a beacon check
  sequence s_beacon;
    st == ST_SLEEP && i_beacon ##1 st == ST_BEACON;
  endsequence
  a_deep_core_off: assert property ((i_deep_off && i_supply_ok) [*8] |->
    st == ST_HIBERNATE && !o_stat.core_en) else $error("core on during deep off");
  a_alert_offline: assert property (off && $past(off) |-> o_alert_oe_n)
    else $error("alert while offline");
  a_boot_time: assert property (st == ST_STANDBY && $past(st) == ST_BOOT |->
    boot_cnt_r + 32'h1 >= BOOT_CYC && boot_cnt_r <= BOOT_CYC + 1) else $error("boot length");
  a_ready_state: assert property ($rose(o_stat.ready) |-> $past(st) == ST_BOOT)
    else $error("ready without boot");
  a_select_fall: assert property (
    $fell(i_spi.cs_n) && o_stat.ready |-> ##[2:6] o_xfer_start) else $error("no start");
  a_select_rise: assert property (
    $rose(i_spi.cs_n) && o_stat.ready |-> ##[2:6] o_xfer_end) else $error("no end");
  a_idle_no_byte: assert property (i_spi.cs_n [*8] |-> !o_host_vld)
    else $error("byte with select high");
  a_beacon_rx: assert property (s_beacon ##0 i_beacon_traffic |=> st == ST_RX_ACTIVE)
    else $error("traffic not fetched");
  a_beacon_sleep: assert property (s_beacon ##0 !i_beacon_traffic |=> st == ST_SLEEP)
    else $error("no return to sleep");
  a_alert_data: assert property (
    i_rx_valid && o_rx_ready && !off |-> ##[1:3] !o_alert_oe_n) else $error("alert late");
endmodule // wmh_props
`default_nettype wire

//--- testbench/wmh_host_model.sv
// Host master model driving the serial pins
`timescale 1ns/100ps
`default_nettype none
module wmh_host_model (
  // Serial pins
  output var wmh_pkg::wmh_spi_in_t o_spi,
  input  wire logic                i_miso
);
  import wmh_pkg::*;
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  logic [7:0] cur;
  logic [7:0] got;
  // Select always driven, idle high
  initial o_spi = 3'b100;
  // One frame of nb bits at 160 ns, mode 3 if m3
  task automatic frame(input logic m3, input int nb);
    #1.5 o_spi.sck = m3;
    #80 o_spi.cs_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      if (i % 8 == 0) cur = (tx_q.size() > 0) ? tx_q.pop_front() : 8'hA5;
      #80 o_spi.sck = 1'b0;
      o_spi.mosi = cur[7 - (i % 8)]; // MSB first, set before rise
      #80 o_spi.sck = 1'b1;
      got = {got[6:0], i_miso}; // Sampled on the rising edge
      if (i % 8 == 7) rx_q.push_back(got);
    end
    #80 o_spi.sck = m3;
    #80 o_spi.cs_n = 1'b1;
    o_spi.mosi = ~o_spi.mosi; // Released line shows no stale bit
  endtask
  // Clock and data wiggle with select high
  task automatic stray(input int n);
    repeat (n) begin
      #80 o_spi.sck = ~o_spi.sck;
      o_spi.mosi = ~o_spi.mosi;
    end
  endtask
endmodule // wmh_host_model
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the module host port
`timescale 1ns/100ps
`default_nettype none
module tb;
  import wmh_pkg::*;
  localparam int unsigned BOOT = 20;
  localparam int unsigned WAKE = 40; // Shortened host settle wait
  logic        i_clk, i_rst_n, i_deep_off, i_mod_rst_n, i_supply_ok, i_cfg_we, i_cfg_ps_en;
  logic        i_tx_req, i_tx_done, i_rx_start, i_rx_done, i_beacon, i_beacon_traffic;
  logic        i_rx_valid, o_spi_miso, o_alert_out, o_alert_oe_n, o_rx_ready, o_host_vld;
  logic        o_xfer_start, o_xfer_end;
  logic [7:0]  i_rx_data, o_host_byte, bb;
  logic [7:0]  exp_q[$], fq[$];
  logic [31:0] seed = 32'h00010FE8;
  wmh_spi_in_t i_spi;
  wmh_stat_t   o_stat;
  int          num_errors = 0, n_compared = 0, n_st = 0, n_en = 0, nf = 0, tick = 0;
  wmh_spi_power_ctrl #(.BOOT_CYC(BOOT), .DEPTH(FIFO_DEPTH)) i_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_deep_off(i_deep_off), .i_mod_rst_n(i_mod_rst_n),
    .i_supply_ok(i_supply_ok), .i_spi(i_spi), .o_spi_miso(o_spi_miso),
    .o_alert_out(o_alert_out), .o_alert_oe_n(o_alert_oe_n), .i_cfg_we(i_cfg_we),
    .i_cfg_ps_en(i_cfg_ps_en), .i_tx_req(i_tx_req), .i_tx_done(i_tx_done),
    .i_rx_start(i_rx_start), .i_rx_done(i_rx_done), .i_beacon(i_beacon),
    .i_beacon_traffic(i_beacon_traffic), .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data),
    .o_rx_ready(o_rx_ready), .o_host_vld(o_host_vld), .o_host_byte(o_host_byte),
    .o_xfer_start(o_xfer_start), .o_xfer_end(o_xfer_end), .o_stat(o_stat));
  wmh_host_model u_host (.o_spi(i_spi), .i_miso(o_spi_miso));
  // Core clock, 4 ns
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait for a power state, then compare
  task automatic wait_st(input wmh_pwr_t s, input int lim);
    int t;
    t = 0;
    while (o_stat.state !== s && t < lim) begin
      @(posedge i_clk);
      t++;
    end
    chk({5'h00, o_stat.state}, {5'h00, s});
  endtask
  // Offer one byte; held until taken
  task automatic push(input logic [7:0] d);
    int t;
    t = 0;
    i_rx_valid <= 1'b1;
    i_rx_data <= d;
    @(posedge i_clk);
    while (o_rx_ready !== 1'b1 && t < 20) begin
      @(posedge i_clk);
      t++;
    end
    fq.push_back(d);
    chk({7'h00, o_rx_ready}, 8'h01);
  endtask
  // One-byte frames in alternating modes; gaps stall the drain
  task automatic rd(input int n);
    for (int k = 0; k < n; k++) begin
      bb = 8'(rnd());
      u_host.tx_q.push_back(bb);
      exp_q.push_back(bb);
      u_host.frame(k[0], 8);
      nf++;
      chk(u_host.rx_q.pop_front(), (fq.size() > 0) ? fq.pop_front() : IDLE_BYTE);
      cyc(3);
    end
  endtask
  task automatic power_up();
    @(posedge i_clk) i_deep_off <= 1'b0; // Hibernate released first
    cyc(WAKE);
    i_mod_rst_n <= 1'b1;
    cyc(BOOT - 5);
    chk({7'h00, o_stat.ready}, 8'h00);
    wait_st(ST_STANDBY, 30);
    chk({7'h00, o_stat.ready}, 8'h01);
  endtask
  task automatic test_done();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Watcher: bytes from the host against the oldest note
  always @(posedge i_clk) begin
    tick++;
    if (o_xfer_start === 1'b1) n_st++;
    if (o_xfer_end === 1'b1) n_en++;
    if (o_host_vld === 1'b1) chk(o_host_byte, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX);
    if (tick == 40000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    {i_rst_n, i_mod_rst_n, i_cfg_we, i_cfg_ps_en, i_tx_req, i_tx_done} = 6'h00;
    {i_rx_start, i_rx_done, i_beacon, i_beacon_traffic, i_rx_valid} = 5'h00;
    {i_deep_off, i_supply_ok, i_rx_data} = 10'h300;
    cyc(6);
    i_rst_n <= 1'b1;
    wait_st(ST_HIBERNATE, 10);
    power_up();
    // Host writes three bytes per frame in each mode
    for (int m = 0; m < 2; m++) begin
      repeat (3) begin
        bb = 8'(rnd());
        u_host.tx_q.push_back(bb);
        exp_q.push_back(bb);
      end
      u_host.frame(m[0], 24);
      nf++;
      repeat (3) chk(u_host.rx_q.pop_front(), IDLE_BYTE);
    end
    // Partial byte dropped, stray clocks ignored
    bb = 8'(rnd());
    u_host.tx_q.push_back(bb);
    u_host.tx_q.push_back(~bb);
    exp_q.push_back(bb);
    u_host.frame(1'b0, 12);
    nf++;
    void'(u_host.rx_q.pop_front());
    u_host.stray(6);
    rd(1);
    // Fill until refused, then drain
    for (int k = 0; k < FIFO_DEPTH; k++) push(8'(rnd()));
    repeat (8) @(posedge i_clk) chk({7'h00, o_rx_ready}, 8'h00);
    i_rx_valid <= 1'b0;
    chk({7'h00, o_alert_oe_n}, 8'h00);
    rd(FIFO_DEPTH);
    chk({7'h00, o_alert_oe_n}, 8'h01);
    // Power save, beacon checks, receive and transmit
    i_cfg_ps_en <= 1'b1;
    i_cfg_we <= 1'b1;
    @(posedge i_clk) i_cfg_we <= 1'b0;
    wait_st(ST_SLEEP, 20);
    for (int t = 0; t < 2; t++) begin
      i_beacon_traffic <= t[0];
      i_beacon <= 1'b1;
      @(posedge i_clk) i_beacon <= 1'b0;
      wait_st(ST_BEACON, 2);
      wait_st(t[0] ? ST_RX_ACTIVE : ST_SLEEP, 3);
    end
    push(8'(rnd()));
    i_rx_valid <= 1'b0;
    i_rx_done <= 1'b1;
    @(posedge i_clk) i_rx_done <= 1'b0;
    wait_st(ST_STANDBY, 4);
    chk({7'h00, o_alert_oe_n}, 8'h00);
    rd(1);
    wait_st(ST_SLEEP, 20);
    i_tx_req <= 1'b1;
    wait_st(ST_TX_ACTIVE, 10);
    i_tx_req <= 1'b0;
    i_tx_done <= 1'b1;
    @(posedge i_clk) i_tx_done <= 1'b0;
    wait_st(ST_SLEEP, 10);
    // Hibernate drops all settings
    i_deep_off <= 1'b1;
    wait_st(ST_HIBERNATE, 8);
    chk({5'h00, o_alert_out, o_stat.core_en, o_alert_oe_n}, 8'h01);
    i_mod_rst_n <= 1'b0;
    power_up();
    cyc(30);
    chk({5'h00, o_stat.state}, {5'h00, ST_STANDBY});
    i_rx_start <= 1'b1;
    wait_st(ST_RX_ACTIVE, 4);
    i_rx_start <= 1'b0;
    i_rx_done <= 1'b1;
    @(posedge i_clk) i_rx_done <= 1'b0;
    wait_st(ST_STANDBY, 4);
    // Supply loss holds the module in reset
    i_supply_ok <= 1'b0;
    wait_st(ST_RESET, 8);
    i_supply_ok <= 1'b1;
    wait_st(ST_STANDBY, BOOT + 20);
    chk(8'(n_st), 8'(nf));
    chk(8'(n_en), 8'(nf));
    chk(8'(exp_q.size()), 8'h00);
    chk(8'(fq.size()), 8'h00);
    test_done();
  end
endmodule // tb
bind wmh_spi_power_ctrl wmh_props #(.BOOT_CYC(BOOT_CYC)) i_props (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_deep_off(i_deep_off), .i_supply_ok(i_supply_ok),
  .i_spi(i_spi), .i_beacon(i_beacon), .i_beacon_traffic(i_beacon_traffic),
  .i_rx_valid(i_rx_valid), .o_rx_ready(o_rx_ready), .o_alert_oe_n(o_alert_oe_n),
  .o_host_vld(o_host_vld), .o_xfer_start(o_xfer_start), .o_xfer_end(o_xfer_end),
  .o_stat(o_stat));
`default_nettype wire
